//--- sucs_cfg.svh
`ifndef SUCS_CFG_SVH
`define SUCS_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SUCS_OFS_COMM 8'h00
`define SUCS_OFS_DATA 8'h04
`define SUCS_OFS_LEVEL 8'h08
`define SUCS_OFS_GATE 8'h0c
`define SUCS_OFS_LATCH 8'h10
`define SUCS_OFS_DIR 8'h14
`define SUCS_OFS_FLAGS 8'h18
`define SUCS_OFS_MASK 8'h1c
`define SUCS_OFS_START 8'h20
`define SUCS_OFS_STOP 8'h24
`define SUCS_OFS_STATUS 8'h28
`define SUCS_OFS_MODE 8'h2c
`define SUCS_OFS_TXDATA 8'h30

// ****************************************
// Field positions
// ****************************************
`define SUCS_TXE_BIT 15
`define SUCS_RXE_BIT 14
`define SUCS_PTC_HI 9
`define SUCS_PTC_LO 8
`define SUCS_DIR_BIT 7
`define SUCS_SLC_HI 5
`define SUCS_SLC_LO 4
`define SUCS_DLS_HI 1
`define SUCS_DLS_LO 0
`define SUCS_DIV_HI 15
`define SUCS_DIV_LO 9
`define SUCS_FLAG_HI 4
`define SUCS_FLAG_LO 2
`define SUCS_TX_PIN 2
`define SUCS_RX_PIN 1

// ****************************************
// Reset values
// ****************************************
`define SUCS_RST_COMM 16'h0000
`define SUCS_RST_DIV 7'h00
`define SUCS_RST_LEVEL 1'b1
`define SUCS_RST_GATE 1'b0
`define SUCS_RST_LATCH 8'h04
`define SUCS_RST_DIR 8'hff
`define SUCS_RST_MASK 3'h7
`endif

//--- sucs_pkg.sv
package sucs_pkg;
   typedef enum logic [2:0] {
      SUCS_IDLE, SUCS_START, SUCS_DATA, SUCS_PARITY, SUCS_STOP
   } sucs_frame_t;
endpackage : sucs_pkg

//--- sucs_baud_gen.sv
module sucs_baud_gen
   import sucs_pkg::*;
   (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   input wire logic [6:0] div_sel,
   output logic half_tick,
   output logic full_tick
   );
   logic [7:0] cnt_reg;
   logic [7:0] term;
   logic [7:0] gap_reg;
   logic seen_reg;

   assign term = {div_sel, 1'b1};
   assign full_tick = !restart && (cnt_reg == term);
   assign half_tick = !restart && (cnt_reg == {1'b0, div_sel});

   // Period of 2(k+1) operation clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 8'h00;
      end else if (restart || full_tick) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg <= 8'h00;
         seen_reg <= 1'b0;
      end else if (restart) begin
         gap_reg <= 8'h00;
         seen_reg <= 1'b0;
      end else if (full_tick) begin
         gap_reg <= 8'h00;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 8'h01;
      end
   end

   tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
      full_tick && seen_reg && $stable(div_sel) |-> gap_reg == term)
      else $error("transfer clock period wrong");
endmodule : sucs_baud_gen

//--- sucs_uart_channel.sv
`include "sucs_cfg.svh"
module sucs_uart_channel
   import sucs_pkg::*;
   (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_rx_pin,
   output logic serial_tx_pin_o,
   output logic serial_tx_pin_oe,
   output logic rx_error_irq,
   output logic rx_done_irq,
   output logic tx_done_irq
   );
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         `SUCS_OFS_COMM, `SUCS_OFS_DATA, `SUCS_OFS_LEVEL, `SUCS_OFS_GATE,
         `SUCS_OFS_LATCH, `SUCS_OFS_DIR, `SUCS_OFS_FLAGS, `SUCS_OFS_MASK,
         `SUCS_OFS_START, `SUCS_OFS_STOP, `SUCS_OFS_STATUS, `SUCS_OFS_MODE,
         `SUCS_OFS_TXDATA: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   function automatic logic [3:0] frame_len(input logic [1:0] code);
      case (code)
         2'b01: frame_len = 4'h9;
         2'b10: frame_len = 4'h7;
         default: frame_len = 4'h8;
      endcase
   endfunction : frame_len

   function automatic logic [8:0] len_mask(input logic [1:0] code);
      case (code)
         2'b01: len_mask = 9'h1ff;
         2'b10: len_mask = 9'h07f;
         default: len_mask = 9'h0ff;
      endcase
   endfunction : len_mask

   function automatic logic [3:0] bit_pos(input logic [3:0] idx, input logic [1:0] code,
                                          input logic lsb);
      bit_pos = lsb ? idx : frame_len(code) - 4'h1 - idx;
   endfunction : bit_pos

   function automatic logic par_bit(input logic [1:0] ptc, input logic x);
      case (ptc)
         2'b10: par_bit = x;
         2'b11: par_bit = ~x;
         default: par_bit = 1'b0;
      endcase
   endfunction : par_bit

   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] comm_reg;
   logic [6:0] div_reg;
   logic [8:0] rx_data_reg;
   logic level_reg;
   logic gate_reg;
   logic [7:0] latch_reg;
   logic [7:0] dir_reg;
   logic [2:0] flags_reg;
   logic [2:0] flags_next;
   logic [2:0] mask_reg;
   logic [1:0] enabled_reg;
   logic [1:0] mode_reg;
   logic [8:0] tx_data_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [31:0] rd_val;
   logic wr_acc;
   logic setup;
   logic [2:0] set_vec;

   logic [1:0] dls;
   logic [1:0] ptc;
   logic [1:0] slc;
   logic lsb_first;
   logic [1:0] stop_need;

   assign dls = comm_reg[`SUCS_DLS_HI:`SUCS_DLS_LO];
   assign ptc = comm_reg[`SUCS_PTC_HI:`SUCS_PTC_LO];
   assign slc = comm_reg[`SUCS_SLC_HI:`SUCS_SLC_LO];
   assign lsb_first = comm_reg[`SUCS_DIR_BIT];
   assign stop_need = (slc == 2'b10) ? 2'd2 : {1'b0, slc[0]};

   assign wr_acc = psel && penable && pwrite;
   assign setup = psel && !penable;
   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   // ****************************************
   // Transmit and receive state
   // ****************************************
   sucs_frame_t tx_state;
   sucs_frame_t rx_state;
   logic [3:0] tx_idx_reg;
   logic [1:0] tx_stops_reg;
   logic tx_bit_reg;
   logic tx_done_set;
   logic [3:0] rx_idx_reg;
   logic [1:0] rx_stops_reg;
   logic [8:0] rx_shift_reg;
   logic rx_perr_reg;
   logic rx_ferr_reg;
   logic rx_done_set;
   logic rx_err_set;
   logic tx_go;
   logic tx_half;
   logic tx_tick;
   logic rx_half;
   logic rx_tick;
   logic rx_sync1_reg;
   logic rx_sync2_reg;
   logic rx_prev_reg;
   logic rx_s;
   logic rx_fall;
   logic rx_armed;
   logic tx_parity;
   logic tx_line;

   assign rd_val = (paddr == `SUCS_OFS_COMM) ? {16'h0000, comm_reg} :
                   (paddr == `SUCS_OFS_DATA) ? {16'h0000, div_reg, rx_data_reg} :
                   (paddr == `SUCS_OFS_LEVEL) ? {31'h0, level_reg} :
                   (paddr == `SUCS_OFS_GATE) ? {31'h0, gate_reg} :
                   (paddr == `SUCS_OFS_LATCH) ? {24'h0, latch_reg} :
                   (paddr == `SUCS_OFS_DIR) ? {24'h0, dir_reg} :
                   (paddr == `SUCS_OFS_FLAGS) ? {27'h0, flags_reg, 2'b00} :
                   (paddr == `SUCS_OFS_MASK) ? {27'h0, mask_reg, 2'b00} :
                   (paddr == `SUCS_OFS_STATUS) ?
                      {28'h0, rx_state != SUCS_IDLE, tx_state != SUCS_IDLE, enabled_reg} :
                   (paddr == `SUCS_OFS_MODE) ? {30'h0, mode_reg} :
                   (paddr == `SUCS_OFS_TXDATA) ? {23'h0, tx_data_reg} : 32'h0;

   // ****************************************
   // Bus answer, taken at setup
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= pwrite ? 32'h0 : rd_val;
         pslverr_reg <= !is_mapped(paddr);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comm_reg <= `SUCS_RST_COMM;
         div_reg <= `SUCS_RST_DIV;
         level_reg <= `SUCS_RST_LEVEL;
         gate_reg <= `SUCS_RST_GATE;
         latch_reg <= `SUCS_RST_LATCH;
         dir_reg <= `SUCS_RST_DIR;
         mask_reg <= `SUCS_RST_MASK;
         mode_reg <= 2'b00;
      end else if (wr_acc) begin
         case (paddr)
            `SUCS_OFS_COMM: comm_reg <= pwdata[15:0];
            `SUCS_OFS_DATA: div_reg <= pwdata[`SUCS_DIV_HI:`SUCS_DIV_LO];
            `SUCS_OFS_LEVEL: level_reg <= pwdata[0];
            `SUCS_OFS_GATE: gate_reg <= pwdata[0];
            `SUCS_OFS_LATCH: latch_reg <= pwdata[7:0];
            `SUCS_OFS_DIR: dir_reg <= pwdata[7:0];
            `SUCS_OFS_MASK: mask_reg <= pwdata[`SUCS_FLAG_HI:`SUCS_FLAG_LO];
            `SUCS_OFS_MODE: mode_reg <= pwdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // Channel start and stop; a start wins over a stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enabled_reg <= 2'b00;
      end else begin
         enabled_reg <= (enabled_reg
                         & ~((wr_acc && paddr == `SUCS_OFS_STOP) ? pwdata[1:0] : 2'b00))
                        | ((wr_acc && paddr == `SUCS_OFS_START) ? pwdata[1:0] : 2'b00);
      end
   end

   // Request flags; hardware set wins over software write
   assign set_vec = {rx_err_set, rx_done_set, tx_done_set};
   assign flags_next = ((wr_acc && paddr == `SUCS_OFS_FLAGS)
                        ? pwdata[`SUCS_FLAG_HI:`SUCS_FLAG_LO] : flags_reg) | set_vec;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= 3'b000;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign rx_error_irq = flags_reg[2] && !mask_reg[2];
   assign rx_done_irq = flags_reg[1] && !mask_reg[1];
   assign tx_done_irq = flags_reg[0] && !mask_reg[0];

   // ****************************************
   // Transmit channel
   // ****************************************
   assign tx_go = wr_acc && paddr == `SUCS_OFS_TXDATA && tx_state == SUCS_IDLE
                  && enabled_reg[0] && comm_reg[`SUCS_TXE_BIT];
   assign tx_parity = par_bit(ptc, ^(tx_data_reg & len_mask(dls)));

   sucs_baud_gen u_tx_baud (
      .pclk(pclk),
      .presetn(presetn),
      .restart(tx_go),
      .div_sel(div_reg),
      .half_tick(tx_half),
      .full_tick(tx_tick)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= SUCS_IDLE;
         tx_data_reg <= 9'h000;
         tx_idx_reg <= 4'h0;
         tx_stops_reg <= 2'd0;
         tx_bit_reg <= 1'b1;
         tx_done_set <= 1'b0;
      end else begin
         tx_done_set <= 1'b0;
         case (tx_state)
            SUCS_IDLE: begin
               if (tx_go) begin
                  tx_data_reg <= pwdata[8:0];
                  tx_bit_reg <= 1'b0;
                  tx_state <= SUCS_START;
               end
            end
            SUCS_START: begin
               if (tx_tick) begin
                  tx_idx_reg <= 4'h0;
                  tx_bit_reg <= tx_data_reg[bit_pos(4'h0, dls, lsb_first)];
                  tx_state <= SUCS_DATA;
               end
            end
            SUCS_DATA: begin
               if (tx_tick) begin
                  if (tx_idx_reg == frame_len(dls) - 4'h1) begin
                     if (ptc != 2'b00) begin
                        tx_bit_reg <= tx_parity;
                        tx_state <= SUCS_PARITY;
                     end else if (stop_need != 2'd0) begin
                        tx_bit_reg <= 1'b1;
                        tx_stops_reg <= 2'd1;
                        tx_state <= SUCS_STOP;
                     end else begin
                        tx_bit_reg <= 1'b1;
                        tx_done_set <= 1'b1;
                        tx_state <= SUCS_IDLE;
                     end
                  end else begin
                     tx_idx_reg <= tx_idx_reg + 4'h1;
                     tx_bit_reg <= tx_data_reg[bit_pos(tx_idx_reg + 4'h1, dls, lsb_first)];
                  end
               end
            end
            SUCS_PARITY: begin
               if (tx_tick) begin
                  tx_bit_reg <= 1'b1;
                  tx_stops_reg <= 2'd1;
                  if (stop_need != 2'd0) begin
                     tx_state <= SUCS_STOP;
                  end else begin
                     tx_done_set <= 1'b1;
                     tx_state <= SUCS_IDLE;
                  end
               end
            end
            SUCS_STOP: begin
               if (tx_tick) begin
                  if (tx_stops_reg < stop_need) begin
                     tx_stops_reg <= tx_stops_reg + 2'd1;
                  end else begin
                     tx_done_set <= 1'b1;
                     tx_state <= SUCS_IDLE;
                  end
               end
            end
            default: tx_state <= SUCS_IDLE;
         endcase
      end
   end

   // Line idles at the level bit; frames pass only while the gate is open
   assign tx_line = (gate_reg && tx_state != SUCS_IDLE) ? tx_bit_reg : level_reg;
   assign serial_tx_pin_o = latch_reg[`SUCS_TX_PIN] && tx_line;
   assign serial_tx_pin_oe = !dir_reg[`SUCS_TX_PIN];

   // ****************************************
   // Receive channel
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sync1_reg <= 1'b1;
         rx_sync2_reg <= 1'b1;
         rx_prev_reg <= 1'b1;
      end else begin
         rx_sync1_reg <= serial_rx_pin;
         rx_sync2_reg <= rx_sync1_reg;
         rx_prev_reg <= rx_s;
      end
   end

   assign rx_s = rx_sync2_reg ^ mode_reg[1];
   assign rx_fall = rx_prev_reg && !rx_s;
   assign rx_armed = enabled_reg[1] && comm_reg[`SUCS_RXE_BIT] && mode_reg[0]
                     && dir_reg[`SUCS_RX_PIN];

   sucs_baud_gen u_rx_baud (
      .pclk(pclk),
      .presetn(presetn),
      .restart(rx_state == SUCS_IDLE),
      .div_sel(div_reg),
      .half_tick(rx_half),
      .full_tick(rx_tick)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= SUCS_IDLE;
         rx_idx_reg <= 4'h0;
         rx_stops_reg <= 2'd0;
         rx_shift_reg <= 9'h000;
         rx_data_reg <= 9'h000;
         rx_perr_reg <= 1'b0;
         rx_ferr_reg <= 1'b0;
         rx_done_set <= 1'b0;
         rx_err_set <= 1'b0;
      end else begin
         rx_done_set <= 1'b0;
         rx_err_set <= 1'b0;
         case (rx_state)
            SUCS_IDLE: begin
               if (rx_armed && rx_fall) begin
                  rx_shift_reg <= 9'h000;
                  rx_perr_reg <= 1'b0;
                  rx_ferr_reg <= 1'b0;
                  rx_state <= SUCS_START;
               end
            end
            SUCS_START: begin
               if (rx_half) begin
                  rx_idx_reg <= 4'h0;
                  rx_state <= rx_s ? SUCS_IDLE : SUCS_DATA;
               end
            end
            SUCS_DATA: begin
               if (rx_half) begin
                  rx_shift_reg[bit_pos(rx_idx_reg, dls, lsb_first)] <= rx_s;
                  rx_idx_reg <= rx_idx_reg + 4'h1;
                  if (rx_idx_reg == frame_len(dls) - 4'h1) begin
                     rx_stops_reg <= 2'd1;
                     rx_state <= (ptc != 2'b00) ? SUCS_PARITY
                               : (stop_need != 2'd0) ? SUCS_STOP : SUCS_IDLE;
                     rx_done_set <= (ptc == 2'b00) && (stop_need == 2'd0);
                  end
               end
            end
            SUCS_PARITY: begin
               if (rx_half) begin
                  rx_perr_reg <= ptc[1] && (rx_s != par_bit(ptc, ^rx_shift_reg));
                  rx_state <= (stop_need != 2'd0) ? SUCS_STOP : SUCS_IDLE;
                  rx_done_set <= (stop_need == 2'd0);
               end
            end
            SUCS_STOP: begin
               if (rx_half) begin
                  if (!rx_s) begin
                     rx_ferr_reg <= 1'b1;
                  end
                  if (rx_stops_reg < stop_need) begin
                     rx_stops_reg <= rx_stops_reg + 2'd1;
                  end else begin
                     rx_done_set <= 1'b1;
                     rx_state <= SUCS_IDLE;
                  end
               end
            end
            default: rx_state <= SUCS_IDLE;
         endcase
         if (rx_done_set) begin
            rx_data_reg <= rx_shift_reg;
            rx_err_set <= rx_perr_reg || rx_ferr_reg;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   start_sets_en_a: assert property (
      wr_acc && paddr == `SUCS_OFS_START && pwdata[0] |=> enabled_reg[0])
      else $error("start trigger did not enable channel");
   zero_no_trig_a: assert property (
      wr_acc && paddr == `SUCS_OFS_START && pwdata[1:0] == 2'b00 |=> $stable(enabled_reg))
      else $error("zero start write changed status");
   idle_line_level_a: assert property (
      tx_state == SUCS_IDLE && latch_reg[2] |-> serial_tx_pin_o == level_reg)
      else $error("idle line not at level bit");
   gate_off_hold_a: assert property (
      !gate_reg && latch_reg[2] && tx_state != SUCS_IDLE |-> serial_tx_pin_o == level_reg)
      else $error("output leaked with gate closed");
   dir_drive_a: assert property (
      wr_acc && paddr == `SUCS_OFS_DIR |=> serial_tx_pin_oe == !$past(pwdata[2]))
      else $error("direction bit not applied");
   tx_done_flag_a: assert property (
      tx_done_set |=> flags_reg[0])
      else $error("transmit end flag lost");
   mask_block_a: assert property (
      wr_acc && paddr == `SUCS_OFS_MASK && pwdata[2] |=> !tx_done_irq)
      else $error("masked request reached output");
   start_bit_low_a: assert property (
      tx_go |=> (tx_state == SUCS_START && !tx_bit_reg) [*2])
      else $error("start bit not low");
   rx_fall_start_a: assert property (
      rx_state == SUCS_IDLE && rx_armed && rx_fall |=> rx_state == SUCS_START)
      else $error("falling edge did not start reception");
   data_len_a: assert property (
      tx_state == SUCS_DATA && tx_tick && ptc != 2'b00 |-> ##1
      tx_state != SUCS_PARITY || $past(tx_idx_reg) == frame_len(dls) - 4'h1)
      else $error("wrong number of data bits");

   tx_frame_c: cover property (tx_done_set);
   rx_frame_c: cover property (rx_done_set);
   rx_error_c: cover property (rx_err_set);
   both_on_c: cover property (enabled_reg == 2'b11);
endmodule : sucs_uart_channel

//--- sucs_remote_dev.sv
module sucs_remote_dev (
   input wire logic pclk,
   input wire logic line_in,
   input wire logic [8:0] period,
   input wire logic [3:0] nbits,
   input wire logic [1:0] par_sel,
   output logic rx_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] got_data;
   logic got_par;
   logic [8:0] tmp;
   initial rx_line = 1'b1;
   // Parity from the code: zero, even or odd over the data bits
   function automatic logic par_of(input logic [8:0] d);
      return (par_sel == 2'b10) ? ^d : (par_sel == 2'b11) ? ~^d : 1'b0;
   endfunction : par_of
   // ****************************************
   // Frame sender: low start, data lsb first, parity if set, two high stops
   // ****************************************
   task automatic send(input logic [8:0] d, input logic flip);
      for (int i = 0; i < nbits + ((par_sel != 2'b00) ? 4 : 3); i++) begin
         if (i == 0)
            rx_line <= 1'b0;
         else if (i <= nbits)
            rx_line <= d[i - 1];
         else if (i == nbits + 1 && par_sel != 2'b00)
            rx_line <= par_of(d) ^ flip;
         else
            rx_line <= 1'b1;
         repeat (period) @(posedge pclk);
      end
   endtask : send
   // ****************************************
   // Frame decoder on the transmit line, mid-bit sampling
   // ****************************************
   always begin
      @(negedge line_in);
      tmp = '0;
      repeat (period / 2) @(posedge pclk);
      for (int i = 0; i < nbits; i++) begin
         repeat (period) @(posedge pclk);
         tmp[i] = line_in;
      end
      got_data = tmp;
      if (par_sel != 2'b00) begin
         repeat (period) @(posedge pclk);
         got_par = line_in;
      end
      repeat (period) @(posedge pclk);
   end
endmodule : sucs_remote_dev

//--- sucs_uart_channel_tb.sv
`include "sucs_cfg.svh"
module sucs_uart_channel_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic tx_o, tx_oe, irq_e, irq_r, irq_t, tx_line, rx_line;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [8:0] period = 9'd4;
   logic [3:0] nbits = 4'd8;
   logic [1:0] par_sel = 2'b00;
   int n_fail, cmp_count, exp;
   int ra[6] = '{`SUCS_OFS_LEVEL, `SUCS_OFS_GATE, `SUCS_OFS_LATCH, `SUCS_OFS_DIR,
      `SUCS_OFS_MASK, `SUCS_OFS_FLAGS};
   int rv[6] = '{1, 0, 'h04, 'hff, 'h1c, 0};
   int nb[3] = '{9, 7, 8};
   int kv[3] = '{1, 77, 127};
   assign tx_line = tx_oe ? tx_o : 1'b1;
   sucs_uart_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_rx_pin(rx_line), .serial_tx_pin_o(tx_o),
      .serial_tx_pin_oe(tx_oe), .rx_error_irq(irq_e), .rx_done_irq(irq_r),
      .tx_done_irq(irq_t));
   sucs_remote_dev remote_u (.pclk(pclk), .line_in(tx_line), .period(period),
      .nbits(nbits), .par_sel(par_sel), .rx_line(rx_line));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task chk(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : chk
   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 50) begin
         n_fail++;
         final_report();
      end
   endtask : apb
   task wait_flag(input int b);
      for (int i = 0; i < 2000; i++) begin
         apb(1'b0, `SUCS_OFS_FLAGS, 32'h0);
         if (rd[b] === 1'b1)
            return;
      end
      n_fail++;
      final_report();
   endtask : wait_flag
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(32'h6df4));
      repeat (20) @(posedge pclk);
      presetn <= 1'b0 | 1'b1;
      @(posedge pclk);
      chk(tx_o, 1);
      chk(tx_oe, 0);
      foreach (ra[i]) begin
         apb(1'b0, ra[i][7:0], 32'h0);
         chk(rd, rv[i]);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[30:0], err}, 1);
      apb(1'b1, `SUCS_OFS_LEVEL, 32'h0);
      apb(1'b1, `SUCS_OFS_DIR, 32'hfb);
      @(posedge pclk);
      chk({tx_oe, tx_o}, 2);
      apb(1'b1, `SUCS_OFS_LEVEL, 32'h1);
      // Let the partner finish decoding the low pulse of the level test
      repeat (50) @(posedge pclk);
      apb(1'b1, `SUCS_OFS_GATE, 32'h1);
      apb(1'b1, `SUCS_OFS_MASK, 32'h0);
      apb(1'b1, `SUCS_OFS_MODE, 32'h1);
      apb(1'b1, `SUCS_OFS_START, 32'h0);
      apb(1'b0, `SUCS_OFS_STATUS, 32'h0);
      chk(rd[1:0], 0);
      foreach (nb[i]) begin
         nbits <= nb[i][3:0];
         period <= 9'(2 * (kv[i] + 1));
         par_sel <= 2'(i + 1);
         exp = 32'hc080 | ((i + 1) * 32'h101) | ((i == 2) ? 32'h20 : 32'h10);
         apb(1'b1, `SUCS_OFS_COMM, exp);
         apb(1'b1, `SUCS_OFS_DATA, kv[i] << 9);
         repeat (4) @(posedge pclk);
         apb(1'b1, `SUCS_OFS_START, 32'h3);
         apb(1'b0, `SUCS_OFS_STATUS, 32'h0);
         chk(rd[1:0], 3);
         exp = $urandom & ((1 << nb[i]) - 1);
         apb(1'b1, `SUCS_OFS_TXDATA, exp);
         wait_flag(2);
         chk(remote_u.got_data, exp);
         chk(remote_u.got_par, remote_u.par_of(exp[8:0]));
         chk(irq_t, 1);
         apb(1'b1, `SUCS_OFS_MASK, 32'h04);
         @(posedge pclk);
         chk(irq_t, 0);
         apb(1'b1, `SUCS_OFS_MASK, 32'h0);
         apb(1'b1, `SUCS_OFS_FLAGS, 32'h0);
         exp = $urandom & ((1 << nb[i]) - 1);
         remote_u.send(exp[8:0], i == 2);
         wait_flag(3);
         chk({irq_e, irq_r}, (i == 2) ? 3 : 1);
         apb(1'b0, `SUCS_OFS_DATA, 32'h0);
         chk(rd & 32'h1ff, exp);
         apb(1'b1, `SUCS_OFS_FLAGS, 32'h0);
      end
      apb(1'b1, `SUCS_OFS_FLAGS, 32'h1c);
      @(posedge pclk);
      chk({irq_e, irq_r, irq_t}, 7);
      apb(1'b1, `SUCS_OFS_MASK, 32'h1c);
      @(posedge pclk);
      chk({irq_e, irq_r, irq_t}, 0);
      apb(1'b1, `SUCS_OFS_STOP, 32'h3);
      apb(1'b0, `SUCS_OFS_STATUS, 32'h0);
      chk(rd[3:0], 0);
      final_report();
   end
endmodule : sucs_uart_channel_tb
